// File: design/crsic_top.sv
/*
 * card reader status, error and interrupt control.
 * register port: Avalon-MM slave, one wait cycle on every access.
 * reader inputs are asynchronous and pass a two-stage synchroniser.
 * column_latch_pulse is taken on a rising edge of the synced input.
 */
// The placing of the registers and register access over Avalon-MM were decided locally.
// Functional notes
// R01: latch while ready sets missed flag, irq
// R02: ready holds until column is read out
// R03: missed flag reads on status bit 28
// R04: control bit 28 clears missed flag
// R05: fault irq needs fault and its enable
// R06: fault reads on status bit 27
// R07: fault irq drops with fault, channel, enable
// R08: file end set by input and hopper empty
// R09: status bits 24,25,26,27,30,31 as listed
// R10: control bit 30 clears file end flag
// R11: hopper empty or stacker full, empty level
// R12: status bits 33..35 give channel
// R13: control bit 24 with card fires offset
// R14: offset pulse never stalls reading
// R15: control bit 23 one-shot, trailing edge clears
// R16: clear resets flags, buffer, channel
// R17: bus reset gives same internal clear
// R18: latch sets ready, data read clears it
// R19: control bit 27 sets or clears enable
// R20: irq on channel when any condition true
`timescale 1ns/1ps
module crsic_top (
    input  wire logic                         mclk_in,
    input  wire logic                         sys_rst_in,
    input  wire logic [3:0]                   avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [31:0]                  avs_writedata_in,
    output logic      [31:0]                  avs_readdata_out,
    output logic                              avs_waitrequest_out,
    input  wire logic                         bus_reset_line_in,
    input  wire logic                         column_latch_pulse_in,
    input  wire logic [crsic_pkg::COL_W-1:0]  column_data_in,
    input  wire logic                         reader_fault_input_in,
    input  wire logic                         file_end_input_in,
    input  wire logic                         hopper_empty_input_in,
    input  wire logic                         stacker_full_input_in,
    input  wire logic                         card_present_in,
    input  wire logic                         card_reading_in,
    input  wire logic                         end_of_card_in,
    output logic                              offset_output_out,
    output logic      [crsic_pkg::CHAN_W-1:0] irq_channel_out,
    output logic                              irq_request_out
);
    import crsic_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        sync1;
        logic [7:0]        sync2;
        logic [COL_W-1:0]  col_s1;
        logic [COL_W-1:0]  col_s2;
        logic              latch_d;
        logic              eoc_d;
        logic              column_ready_flag;
        logic              missed_column_flag;
        logic              file_end_flag;
        logic              end_card_flag;
        logic              fault_irq_enable;
        logic [CHAN_W-1:0] chan;
        logic [COL_W-1:0]  col_buf;
        logic [CNT_W-1:0]  offset_cnt;
        logic              offset_oneshot;
        logic [CNT_W-1:0]  clr_cnt;
        logic              clear_delay_oneshot;
        logic              bus_rst_d;
        logic              ack;
        logic [31:0]       rdata;
        logic              irq;
    } crsic_state_type;

    crsic_state_type st_reg;
    crsic_state_type st_next;

    logic [7:0] raw_in;
    logic       latch_s;
    logic       fault_s;
    logic       eof_s;
    logic       hopper_s;
    logic       stacker_s;
    logic       card_s;
    logic       reading_s;
    logic       eoc_s;
    logic       hopper_empty_level;
    logic       reader_fault_level;
    logic       latch_edge;
    logic       internal_clear;
    logic       wr_ctrl;
    logic       rd_data;
    logic [31:0] status_word;

    assign raw_in = {column_latch_pulse_in, reader_fault_input_in,
                     file_end_input_in, hopper_empty_input_in,
                     stacker_full_input_in, card_present_in,
                     card_reading_in, end_of_card_in};
    assign latch_s   = st_reg.sync2[7];
    assign fault_s   = st_reg.sync2[6];
    assign eof_s     = st_reg.sync2[5];
    assign hopper_s  = st_reg.sync2[4];
    assign stacker_s = st_reg.sync2[3];
    assign card_s    = st_reg.sync2[2];
    assign reading_s = st_reg.sync2[1];
    assign eoc_s     = st_reg.sync2[0];

    assign hopper_empty_level = hopper_s | stacker_s;  // see R11
    assign reader_fault_level = fault_s;
    assign latch_edge = latch_s & ~st_reg.latch_d;

    // a bus access completes in the cycle its ack flop is high
    assign wr_ctrl = avs_write_in & st_reg.ack &
                     (avs_address_in == ADDR_CTRL);
    assign rd_data = avs_read_in & st_reg.ack &
                     (avs_address_in == ADDR_DATA);

    // clear fires at the one-shot's trailing edge or on bus reset edge
    assign internal_clear =
        (st_reg.clear_delay_oneshot && st_reg.clr_cnt == CNT_W'(1)) ||
        (bus_reset_line_in && !st_reg.bus_rst_d);  // see R15 see R17

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[BIT_CARD]    = card_s;              // see R09
        status_word[BIT_HOPPER]  = hopper_empty_level;  // see R09 see R11
        status_word[BIT_READING] = reading_s;           // see R09
        status_word[BIT_FAULT]   = reader_fault_level;  // see R06
        status_word[BIT_MISSED]  = st_reg.missed_column_flag;  // see R03
        status_word[BIT_EOF]     = st_reg.file_end_flag;       // see R09
        status_word[BIT_EOC]     = st_reg.end_card_flag;       // see R09
        status_word[BIT_READY]   = st_reg.column_ready_flag;
        status_word[CHAN_LSB +: CHAN_W] = st_reg.chan;         // see R12
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.sync1     = raw_in;
        st_next.sync2     = st_reg.sync1;
        st_next.col_s1    = column_data_in;
        st_next.col_s2    = st_reg.col_s1;
        st_next.latch_d   = latch_s;
        st_next.eoc_d     = eoc_s;
        st_next.bus_rst_d = bus_reset_line_in;

        // bus handshake: one wait cycle, then ack for one cycle
        st_next.ack = (avs_read_in | avs_write_in) & ~st_reg.ack;
        if (avs_read_in && !st_reg.ack) begin
            case (avs_address_in)
                ADDR_CTRL:   st_next.rdata = 32'h0000_0000 |
                                 {23'h00_0000, st_reg.fault_irq_enable,
                                  8'h00};
                ADDR_STATUS: st_next.rdata = status_word;
                ADDR_DATA:   st_next.rdata = {20'h0_0000, st_reg.col_buf};
                default:     st_next.rdata = 32'h0000_0000;
            endcase
        end

        // clears by software come first so that a same-cycle set wins
        if (wr_ctrl) begin
            st_next.fault_irq_enable = avs_writedata_in[BIT_FLT_EN];  // see R19
            if (avs_writedata_in[BIT_MISSED])
                st_next.missed_column_flag = 1'b0;  // see R04
            if (avs_writedata_in[BIT_EOF])
                st_next.file_end_flag = 1'b0;       // see R10
            if (avs_writedata_in[BIT_EOC])
                st_next.end_card_flag = 1'b0;
            if (avs_writedata_in[BIT_READY])
                st_next.column_ready_flag = 1'b0;
            st_next.chan = avs_writedata_in[CHAN_LSB +: CHAN_W];
            if (avs_writedata_in[BIT_CLEAR]) begin
                st_next.clear_delay_oneshot = 1'b1;  // see R15
                st_next.clr_cnt = CNT_W'(CLEAR_DLY_CYC);
            end
            if (avs_writedata_in[BIT_OFFSET] && card_s) begin
                st_next.offset_oneshot = 1'b1;       // see R13
                st_next.offset_cnt = CNT_W'(OFFSET_CYC);
            end
        end

        // trailing edge of the data read clears ready
        if (rd_data)
            st_next.column_ready_flag = 1'b0;  // see R02 see R18

        // the offset pulse runs alone; nothing below waits on it
        if (st_reg.offset_oneshot) begin       // see R14
            st_next.offset_cnt = st_reg.offset_cnt - CNT_W'(1);
            if (st_reg.offset_cnt == CNT_W'(1))
                st_next.offset_oneshot = 1'b0;
        end
        if (st_reg.clear_delay_oneshot) begin
            st_next.clr_cnt = st_reg.clr_cnt - CNT_W'(1);
            if (st_reg.clr_cnt == CNT_W'(1))
                st_next.clear_delay_oneshot = 1'b0;
        end

        if (latch_edge) begin
            st_next.col_buf = st_reg.col_s2;
            st_next.column_ready_flag = 1'b1;  // see R18
            if (st_reg.column_ready_flag)
                st_next.missed_column_flag = 1'b1;  // see R01
        end
        if (eof_s && hopper_empty_level)
            st_next.file_end_flag = 1'b1;      // see R08
        if (!eoc_s && st_reg.eoc_d)
            st_next.end_card_flag = 1'b1;

        if (internal_clear) begin               // see R16
            st_next.column_ready_flag   = 1'b0;
            st_next.missed_column_flag  = 1'b0;
            st_next.file_end_flag       = 1'b0;
            st_next.end_card_flag       = 1'b0;
            st_next.fault_irq_enable    = 1'b0;
            st_next.chan                = CHAN_RESET;
            st_next.col_buf             = '0;
            st_next.offset_oneshot      = 1'b0;
            st_next.clear_delay_oneshot = 1'b0;
        end

        // channel zero disables every request
        st_next.irq = (st_next.chan != CHAN_RESET) &&
                      (st_next.column_ready_flag ||
                       st_next.missed_column_flag ||
                       (reader_fault_level && st_next.fault_irq_enable) ||
                       st_next.file_end_flag ||
                       st_next.end_card_flag);  // see R05 see R07 see R20
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_reg.ack;
    assign avs_readdata_out    = st_reg.rdata;
    assign offset_output_out   = st_reg.offset_oneshot;
    assign irq_channel_out     = st_reg.chan;
    assign irq_request_out     = st_reg.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    localparam int CLR_WAIT = CLEAR_DLY_CYC;

    sequence s_clear_write;
        wr_ctrl && avs_writedata_in[BIT_CLEAR] && !internal_clear;
    endsequence

    sequence s_ready_and_latch;
        st_reg.column_ready_flag && latch_edge && !internal_clear;
    endsequence

    a_missed_on_latch: assert property (  // see R01
        @(posedge mclk_in) disable iff (sys_rst_in)
        s_ready_and_latch |=> st_reg.missed_column_flag)
        else $error("missed flag not set on overrun");

    a_ready_after_read: assert property (  // see R02
        @(posedge mclk_in) disable iff (sys_rst_in)
        st_reg.column_ready_flag && !rd_data && !wr_ctrl &&
        !internal_clear |=> st_reg.column_ready_flag)
        else $error("ready dropped without data read");

    a_missed_clear: assert property (  // see R04
        @(posedge mclk_in) disable iff (sys_rst_in)
        wr_ctrl && avs_writedata_in[BIT_MISSED] && !latch_edge
        |=> !st_reg.missed_column_flag)
        else $error("missed flag not cleared by control");

    a_fault_irq: assert property (  // see R05
        @(posedge mclk_in) disable iff (sys_rst_in)
        reader_fault_level && st_reg.fault_irq_enable &&
        st_reg.chan != CHAN_RESET && !internal_clear && !wr_ctrl
        |=> irq_request_out)
        else $error("fault irq missing");

    a_eof_clear: assert property (  // see R10
        @(posedge mclk_in) disable iff (sys_rst_in)
        wr_ctrl && avs_writedata_in[BIT_EOF] &&
        !(eof_s && hopper_empty_level) |=> !st_reg.file_end_flag)
        else $error("file end flag not cleared");

    a_offset_width: assert property (  // see R13
        @(posedge mclk_in) disable iff (sys_rst_in)
        $rose(offset_output_out) && !internal_clear
        |-> st_reg.offset_cnt == CNT_W'(OFFSET_CYC))
        else $error("offset pulse width wrong");

    a_clear_effect: assert property (  // see R16
        @(posedge mclk_in) disable iff (sys_rst_in)
        internal_clear |=> st_reg.chan == CHAN_RESET &&
        !st_reg.column_ready_flag && !st_reg.missed_column_flag)
        else $error("internal clear incomplete");

    a_bus_reset: assert property (  // see R17
        @(posedge mclk_in) disable iff (sys_rst_in)
        $rose(bus_reset_line_in) |=> irq_channel_out == CHAN_RESET)
        else $error("bus reset did not clear");

    a_chan_zero: assert property (  // see R20
        @(posedge mclk_in) disable iff (sys_rst_in)
        irq_channel_out == CHAN_RESET |-> !irq_request_out)
        else $error("irq on channel zero");

    // a bus reset inside the window kills the one-shot, so it stops the check
    a_clear_delay: assert property (  // see R15
        @(posedge mclk_in) disable iff (sys_rst_in || bus_reset_line_in)
        s_clear_write |-> ##CLR_WAIT internal_clear)
        else $error("clear not at end of one-shot");

    a_ready_on_latch: assert property (  // see R18
        @(posedge mclk_in) disable iff (sys_rst_in)
        latch_edge && !internal_clear |=> st_reg.column_ready_flag)
        else $error("ready not set by column latch");

    a_ready_read_clear: assert property (  // see R18
        @(posedge mclk_in) disable iff (sys_rst_in)
        rd_data && !latch_edge && !internal_clear
        |=> !st_reg.column_ready_flag)
        else $error("ready not cleared by data read");

    a_eof_set_cause: assert property (  // see R08
        @(posedge mclk_in) disable iff (sys_rst_in)
        $rose(st_reg.file_end_flag)
        |-> $past(eof_s) && $past(hopper_empty_level))
        else $error("file end flag set without cause");

    a_fault_status_bit: assert property (  // see R06
        @(posedge mclk_in) disable iff (sys_rst_in)
        avs_read_in && !st_reg.ack && avs_address_in == ADDR_STATUS
        |=> avs_readdata_out[BIT_FAULT] == $past(reader_fault_level))
        else $error("fault status bit wrong");

    a_offset_no_card: assert property (  // see R13
        @(posedge mclk_in) disable iff (sys_rst_in)
        wr_ctrl && avs_writedata_in[BIT_OFFSET] && !card_s &&
        !offset_output_out |=> !offset_output_out)
        else $error("offset fired without card");

endmodule // crsic_top

// File: design/crsic_pkg.sv
/*
 * package for the card reader status and interrupt control block:
 * register map, field positions, reset values and timing constants.
 * assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
 */
package crsic_pkg;

    // ------------------------------------------------------------------
    // clock and one-shot timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int OFFSET_US       = 25;
    localparam int CLEAR_DLY_US    = 1;
    localparam int OFFSET_CYC      = (OFFSET_US * (CLK_HZ / 1_000_000));
    localparam int CLEAR_DLY_CYC   = (CLEAR_DLY_US * (CLK_HZ / 1_000_000));
    localparam int CNT_W           = 10;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_DATA   = 4'h8;

    // control and status word bits; bus bit n maps to register bit (35 - n)
    localparam int BIT_CLEAR    = 12;  // bus 23
    localparam int BIT_OFFSET   = 11;  // bus 24
    localparam int BIT_FLT_EN   = 8;   // bus 27
    localparam int BIT_MISSED   = 7;   // bus 28
    localparam int BIT_EOF      = 5;   // bus 30
    localparam int BIT_EOC      = 4;   // bus 31
    localparam int BIT_READY    = 3;   // bus 32
    localparam int BIT_CARD     = 11;  // bus 24
    localparam int BIT_HOPPER   = 10;  // bus 25
    localparam int BIT_READING  = 9;   // bus 26
    localparam int BIT_FAULT    = 8;   // bus 27
    localparam int CHAN_LSB     = 0;   // bus 33..35
    localparam int CHAN_W       = 3;
    localparam int COL_W        = 12;

    localparam logic [2:0] CHAN_RESET = 3'h0;

endpackage : crsic_pkg

// File: bench/crsic_reader_model.sv
/*
 * card reader model: column strobes with data, and the reader's levels.
 * assumes the bench calls its tasks and mclk_in is the system clock.
 */
`timescale 1ns/1ps
module crsic_reader_model (
    input  wire logic                        mclk_in,
    output logic                             latch_out,
    output logic [crsic_pkg::COL_W-1:0]      col_out,
    output logic [6:0]                       lines_out
);
    import crsic_pkg::*;
    initial begin
        latch_out = 1'b0;
        col_out   = 12'h000;
        lines_out = 7'h00;
    end
    // ------------------------------------------------------------------
    // column strobe: settle, pulse, hold, release
    // ------------------------------------------------------------------
    task automatic send_column(input logic [COL_W-1:0] d);
        @(posedge mclk_in);
        col_out <= d;
        repeat (2) @(posedge mclk_in);
        latch_out <= 1'b1;
        repeat (6) @(posedge mclk_in);
        latch_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
        // released lines float; the inverse keeps stale data from matching
        col_out <= ~d;
    endtask
    // bit 6 fault, 5 file end, 4 hopper, 3 stacker, 2 card, 1 read, 0 eoc
    task automatic set_lines(input logic [6:0] x);
        @(posedge mclk_in);
        lines_out <= x;
        repeat (5) @(posedge mclk_in);
    endtask
endmodule // crsic_reader_model

// File: bench/tb_card_reader_status_irq_control.sv
/*
 * self-checking bench for the card reader status and interrupt control.
 * assumes crsic_pkg, crsic_top and crsic_reader_model compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module tb_card_reader_status_irq_control;
    import crsic_pkg::*;
    localparam logic [6:0]  L_FLT = 7'h40;
    localparam logic [6:0]  L_EOF = 7'h20;
    localparam logic [6:0]  L_HOP = 7'h10;
    localparam logic [6:0]  L_STK = 7'h08;
    localparam logic [6:0]  L_CRD = 7'h04;
    localparam logic [31:0] CH3   = 32'h0000_0003;
    localparam logic [31:0] CH5   = 32'h0000_0005;
    logic               mclk_in;
    logic               sys_rst_in;
    logic [3:0]         avs_address_in;
    logic               avs_read_in;
    logic               avs_write_in;
    logic [31:0]        avs_writedata_in;
    logic               bus_reset_line_in;
    logic [31:0]        avs_readdata_out;
    logic               avs_waitrequest_out;
    logic               latch;
    logic [COL_W-1:0]   col;
    logic [6:0]         ln;
    logic               offset_output_out;
    logic [CHAN_W-1:0]  irq_channel_out;
    logic               irq_request_out;
    logic [31:0]        v;
    int                 n_errors = 0;
    int                 compares = 0;
    int                 n;
    crsic_top u_dut (
        .mclk_in               (mclk_in),
        .sys_rst_in            (sys_rst_in),
        .avs_address_in        (avs_address_in),
        .avs_read_in           (avs_read_in),
        .avs_write_in          (avs_write_in),
        .avs_writedata_in      (avs_writedata_in),
        .avs_readdata_out      (avs_readdata_out),
        .avs_waitrequest_out   (avs_waitrequest_out),
        .bus_reset_line_in     (bus_reset_line_in),
        .column_latch_pulse_in (latch),
        .column_data_in        (col),
        .reader_fault_input_in (ln[6]),
        .file_end_input_in     (ln[5]),
        .hopper_empty_input_in (ln[4]),
        .stacker_full_input_in (ln[3]),
        .card_present_in       (ln[2]),
        .card_reading_in       (ln[1]),
        .end_of_card_in        (ln[0]),
        .offset_output_out     (offset_output_out),
        .irq_channel_out       (irq_channel_out),
        .irq_request_out       (irq_request_out)
    );
    crsic_reader_model u_rdr (
        .mclk_in   (mclk_in),
        .latch_out (latch),
        .col_out   (col),
        .lines_out (ln)
    );
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // ------------------------------------------------------------------
    // bus master: hold the request until waitrequest is sampled low
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] wd);
        @(posedge mclk_in);
        avs_address_in   <= a;
        avs_writedata_in <= wd;
        avs_write_in     <= w;
        avs_read_in      <= ~w;
        // only the watchdog ends a wait that never finishes
        do begin
            @(posedge mclk_in);
        end while (avs_waitrequest_out !== 1'b0);
        v = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask
    function automatic logic [31:0] bt(input int b);
        return 32'h0000_0001 << b;
    endfunction
    // control write, then room for sync and registered outputs to land
    task automatic ctl(input logic [31:0] d);
        bus(1'b1, ADDR_CTRL, d);
        repeat (4) @(posedge mclk_in);
    endtask
    task automatic st_is(input string nm, input logic [31:0] e);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(nm, e, v)
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge mclk_in);
        n_errors++;
        stop_test();
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        sys_rst_in        <= 1'b1;
        avs_address_in    <= 4'h0;
        avs_read_in       <= 1'b0;
        avs_write_in      <= 1'b0;
        avs_writedata_in  <= 32'h0000_0000;
        bus_reset_line_in <= 1'b0;
        repeat (16) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        st_is("st_rst", 32'h0000_0000);
        bus(1'b1, 4'hC, CH5);
        bus(1'b0, 4'hC, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, v)
        st_is("st_unm", 32'h0000_0000);
        $display("test reset done");
        ctl(bt(BIT_FLT_EN) | CH5);
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK("ctl_rd", bt(BIT_FLT_EN), v)
        u_rdr.set_lines(L_FLT);
        st_is("st_flt", bt(BIT_FAULT) | CH5);
        `CHK("irq_flt", 1'b1, irq_request_out)
        `CHK("chan", 3'h5, irq_channel_out)
        ctl(CH5);
        `CHK("irq_noen", 1'b0, irq_request_out)
        ctl(bt(BIT_FLT_EN));
        `CHK("irq_ch0", 1'b0, irq_request_out)
        ctl(bt(BIT_FLT_EN) | CH5);
        `CHK("irq_reen", 1'b1, irq_request_out)
        u_rdr.set_lines(7'h00);
        `CHK("irq_fdrop", 1'b0, irq_request_out)
        $display("test fault done");
        ctl(CH3);
        u_rdr.set_lines(L_HOP);
        st_is("st_hop", bt(BIT_HOPPER) | CH3);
        u_rdr.set_lines(L_STK);
        st_is("st_stk", bt(BIT_HOPPER) | CH3);
        u_rdr.set_lines(L_EOF);
        st_is("st_eof0", CH3);
        u_rdr.set_lines(L_EOF | L_STK);
        u_rdr.set_lines(7'h00);
        st_is("st_eof1", bt(BIT_EOF) | CH3);
        `CHK("irq_eof", 1'b1, irq_request_out)
        ctl(bt(BIT_EOF) | CH3);
        st_is("st_eofc", CH3);
        u_rdr.set_lines(7'h07);
        st_is("st_card", bt(BIT_CARD) | bt(BIT_READING) | CH3);
        u_rdr.set_lines(7'h00);
        st_is("st_eoc", bt(BIT_EOC) | CH3);
        ctl(bt(BIT_EOC) | CH3);
        `CHK("irq_eocc", 1'b0, irq_request_out)
        $display("test status done");
        u_rdr.send_column(12'hA5C);
        st_is("st_rdy", bt(BIT_READY) | CH3);
        st_is("st_rdy2", bt(BIT_READY) | CH3);
        bus(1'b0, ADDR_DATA, 32'h0000_0000);
        `CHK("col1", 32'h0000_0A5C, v)
        st_is("st_rdyc", CH3);
        u_rdr.send_column(12'h123);
        u_rdr.send_column(12'h3C7);
        st_is("st_mis", bt(BIT_READY) | bt(BIT_MISSED) | CH3);
        bus(1'b0, ADDR_DATA, 32'h0000_0000);
        `CHK("col2", 32'h0000_03C7, v)
        st_is("st_mis2", bt(BIT_MISSED) | CH3);
        `CHK("irq_mis", 1'b1, irq_request_out)
        ctl(bt(BIT_MISSED) | CH3);
        st_is("st_misc", CH3);
        `CHK("irq_misc", 1'b0, irq_request_out)
        $display("test column done");
        u_rdr.set_lines(L_CRD);
        bus(1'b1, ADDR_CTRL, bt(BIT_OFFSET) | CH3);
        fork
            begin
                for (int k = 0; k < 20 && offset_output_out !== 1'b1; k++)
                    @(posedge mclk_in);
                n = 0;
                while (offset_output_out === 1'b1 && n < 2000) begin
                    @(posedge mclk_in);
                    n++;
                end
            end
            begin
                u_rdr.send_column(12'h0F0);
                bus(1'b0, ADDR_DATA, 32'h0000_0000);
                `CHK("col_off", 32'h0000_00F0, v)
                `CHK("off_on", 1'b1, offset_output_out)
            end
        join
        `CHK("off_len", OFFSET_CYC, n)
        u_rdr.set_lines(7'h00);
        ctl(bt(BIT_OFFSET) | CH3);
        repeat (30) @(posedge mclk_in);
        `CHK("off_nocard", 1'b0, offset_output_out)
        $display("test offset done");
        u_rdr.send_column(12'h111);
        bus(1'b1, ADDR_CTRL, bt(BIT_CLEAR) | CH3);
        // the clear lands only at the one-shot's trailing edge
        repeat (CLEAR_DLY_CYC / 2) @(posedge mclk_in);
        `CHK("irq_pre", 1'b1, irq_request_out)
        repeat (CLEAR_DLY_CYC) @(posedge mclk_in);
        st_is("st_clr", 32'h0000_0000);
        bus(1'b0, ADDR_DATA, 32'h0000_0000);
        `CHK("col_clr", 32'h0000_0000, v)
        ctl(CH5);
        u_rdr.send_column(12'h222);
        bus_reset_line_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        bus_reset_line_in <= 1'b0;
        repeat (CLEAR_DLY_CYC + 4) @(posedge mclk_in);
        st_is("st_brst", 32'h0000_0000);
        `CHK("chan_brst", 3'h0, irq_channel_out)
        $display("test clear done");
        stop_test();
    end
endmodule // tb_card_reader_status_irq_control
